// file: rtl/wdcfg_pkg.sv
package wdcfg_pkg;

   // Register offsets in port space; data space adds a fixed bias
   localparam logic [7:0] CTL_IO_OFF = 8'h21;
   localparam logic [7:0] CAUSE_IO_OFF = 8'h34;
   localparam logic [7:0] DATA_SPACE_BIAS = 8'h20;

   // Control register fields
   localparam int CTL_UNLOCK_BIT = 4;
   localparam int CTL_ON_BIT = 3;
   localparam int CTL_SEL_MSB = 2;
   localparam int SEL_W = 3;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // Reset-cause register fields
   localparam int CAUSE_SCAN_BIT = 4;
   localparam int CAUSE_WD_BIT = 3;
   localparam int CAUSE_BO_BIT = 2;
   localparam int CAUSE_PIN_BIT = 1;
   localparam int CAUSE_PWR_BIT = 0;
   localparam int CAUSE_W = 5;
   localparam logic [4:0] CAUSE_POR_VAL = 5'h01;
   localparam logic [4:0] CAUSE_LEGACY_MASK = 5'h03;
   localparam logic [4:0] CAUSE_FULL_MASK = 5'h1f;

   // Change window length in system clock cycles
   localparam int WIN_CYC = 4;
   localparam logic [2:0] WIN_LAST = 3'(WIN_CYC - 1);

   // Shortest time-out is two to this power oscillator cycles
   localparam int TIMEOUT_BASE_LOG2 = 14;

   // Safety levels selected by the two fuses
   typedef enum logic [2:0] {
      WDCFG_LVL0 = 3'b001,
      WDCFG_LVL1 = 3'b010,
      WDCFG_LVL2 = 3'b100
   } wdcfg_level_t;

   // Always-on fuse dominates; compat fuse alone gives level zero
   function automatic wdcfg_level_t wdcfg_level(input logic compat, input logic always_on);
      wdcfg_level_t lvl;
      if (always_on) begin
         lvl = WDCFG_LVL2;
      end else if (compat) begin
         lvl = WDCFG_LVL0;
      end else begin
         lvl = WDCFG_LVL1;
      end
      return lvl;
   endfunction : wdcfg_level

endpackage : wdcfg_pkg

// file: rtl/wdcfg_timeout_counter.sv
`timescale 1ns/100ps
`default_nettype none
module wdcfg_timeout_counter
   import wdcfg_pkg::*;
#(
   parameter int BASE_LOG2 = TIMEOUT_BASE_LOG2,
   parameter int CNT_W = BASE_LOG2 + 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic tick_i,
   input wire logic clear_i,
   input wire logic run_i,
   input wire logic [2:0] sel_i,
   output logic expire_o
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic expire_r;
   logic expire_nxt;
   logic [CNT_W-1:0] last;

   // Last count before expiry, doubling with each select code
   assign last = CNT_W'((32'd1 << (32'(BASE_LOG2) + 32'(sel_i))) - 32'd1);

   // Greater-or-equal so a shortened time-out mid-count still fires
   always_comb begin
      cnt_nxt = cnt_r;
      expire_nxt = 1'b0;
      if (clear_i || !run_i) begin
         cnt_nxt = '0;
      end else if (tick_i) begin
         if (cnt_r >= last) begin
            cnt_nxt = '0;
            expire_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   // Counter state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         expire_r <= 1'b0;
      end else if (ce_i) begin
         cnt_r <= cnt_nxt;
         expire_r <= expire_nxt;
      end
   end

   assign expire_o = expire_r;

endmodule : wdcfg_timeout_counter
`default_nettype wire

// file: rtl/wdcfg_top.sv
// What this block does
// - Levels zero and one start disabled; writing enable one turns it on anytime.
// - Level zero accepts a new time-out select on any write.
// - Level one ignores select changes or disabling unless the window is open.
// - Level one: one write within four cycles sets enable and select.
// - Level two: watchdog always runs, enable always reads one.
// - Level two: select change within four cycles after opening; enable ignored.
// - Level two never disables the watchdog, even with the full sequence.
// - Hardware clears the unlock bit four cycles after it was set.
// - Enable clears only while the unlock bit is one.
// - Levels zero and one: open window, then clear enable within four cycles.
// - Select codes pick 16384 doubling up to 2097152 oscillator cycles.
// - Select field bits two to zero set the running time-out.
// - Scan flag bit 4 set by scan reset; cleared by power-up or zero.
// - Watchdog flag bit 3 set by watchdog reset; cleared likewise.
// - Brown-out flag bit 2 set by brown-out reset; cleared likewise.
// - Pin flag bit 1 set by external reset; cleared likewise.
// - Power-up flag bit 0 set by power-up; only a zero write clears it.
// - Legacy mode keeps only the pin and power-up flags.
// - Reset-cause register at port 0x34, data space 0x54.
// - Control register at port 0x21, data space 0x41.
// - Expiry gives a one-cycle reset pulse.
// - Counter cleared by restart, when disabled, and by chip reset.
// - Two fuses pick one of three safety levels.
`timescale 1ns/100ps
`default_nettype none
module wdcfg_top
   import wdcfg_pkg::*;
#(
   parameter int BASE_LOG2 = TIMEOUT_BASE_LOG2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic ce_i,
   input wire logic io_sel_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   input wire logic legacy_compat_fuse_i,
   input wire logic always_on_fuse_i,
   input wire logic wdt_osc_i,
   input wire logic restart_i,
   input wire logic pin_reset_i,
   input wire logic brownout_reset_i,
   input wire logic scan_reset_i,
   output logic wdt_reset_o,
   output logic watchdog_on_o,
   output logic [2:0] timeout_select_o
);

   // Address match in port space or with the data-space bias
   function automatic logic reg_hit(input logic port_space, input logic [7:0] addr,
                                    input logic [7:0] io_off);
      logic hit;
      if (port_space) begin
         hit = (addr == io_off);
      end else begin
         hit = (addr == io_off + DATA_SPACE_BIAS);
      end
      return hit;
   endfunction : reg_hit

   wdcfg_level_t level;
   logic ctl_hit;
   logic cause_hit;
   logic ctl_wr;
   logic cause_wr;
   logic w_unlock;
   logic w_on;
   logic [2:0] w_sel;
   logic reopen;

   assign level = wdcfg_level(legacy_compat_fuse_i, always_on_fuse_i);

   assign cause_hit = reg_hit(io_sel_i, addr_i, CAUSE_IO_OFF);
   assign ctl_hit = reg_hit(io_sel_i, addr_i, CTL_IO_OFF);

   assign ctl_wr = wr_i && ctl_hit;
   assign cause_wr = wr_i && cause_hit;
   assign w_unlock = wdata_i[CTL_UNLOCK_BIT];
   assign w_on = wdata_i[CTL_ON_BIT];
   assign w_sel = wdata_i[CTL_SEL_MSB:0];
   assign reopen = ctl_wr && w_unlock && w_on;

   // Control register state
   logic unlock_r;
   logic unlock_nxt;
   logic [2:0] win_cnt_r;
   logic [2:0] win_cnt_nxt;
   logic on_r;
   logic on_nxt;
   logic [2:0] sel_r;
   logic [2:0] sel_nxt;

   // Next control state; window tested before this write changes it
   always_comb begin
      unlock_nxt = unlock_r;
      win_cnt_nxt = win_cnt_r;
      on_nxt = on_r;
      sel_nxt = sel_r;
      if (unlock_r) begin
         if (win_cnt_r == WIN_LAST) begin
            unlock_nxt = 1'b0;
            win_cnt_nxt = 3'h0;
         end else begin
            win_cnt_nxt = win_cnt_r + 3'h1;
         end
      end
      if (ctl_wr) begin
         if (w_on) begin
            on_nxt = 1'b1;
         end else if (unlock_r) begin
            on_nxt = 1'b0;
         end
         case (level)
            WDCFG_LVL0: begin
               sel_nxt = w_sel;
            end
            WDCFG_LVL1: begin
               if (unlock_r) begin
                  sel_nxt = w_sel;
               end
            end
            WDCFG_LVL2: begin
               if (unlock_r) begin
                  sel_nxt = w_sel;
               end
            end
            default: begin
               sel_nxt = sel_r;
            end
         endcase
         // a write opens or closes the window
         unlock_nxt = reopen;
         win_cnt_nxt = 3'h0;
      end
      // level two forces the watchdog on
      if (level == WDCFG_LVL2) begin
         on_nxt = 1'b1;
      end
   end

   // Control registers, cleared on chip reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         unlock_r <= CTL_RESET[CTL_UNLOCK_BIT];
         win_cnt_r <= 3'h0;
         on_r <= CTL_RESET[CTL_ON_BIT];
         sel_r <= CTL_RESET[CTL_SEL_MSB:0];
      end else if (ce_i) begin
         unlock_r <= unlock_nxt;
         win_cnt_r <= win_cnt_nxt;
         on_r <= on_nxt;
         sel_r <= sel_nxt;
      end
   end

   // Oscillator synchroniser; first stage feeds only the second
   logic osc_s1_r;
   logic osc_s2_r;
   logic osc_s3_r;
   logic osc_tick;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
      end else if (ce_i) begin
         osc_s1_r <= wdt_osc_i;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
      end
   end

   // edge after sync; settings apply per tick
   assign osc_tick = osc_s2_r && !osc_s3_r;

   logic expire;

   wdcfg_timeout_counter #(
      .BASE_LOG2(BASE_LOG2)
   ) u_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .tick_i(osc_tick),
      .clear_i(restart_i),
      .run_i(on_r),
      .sel_i(sel_r),
      .expire_o(expire)
   );

   // Reset pulse and status outputs
   logic pulse_r;
   logic pulse_nxt;

   assign pulse_nxt = expire;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pulse_r <= 1'b0;
      end else if (ce_i) begin
         pulse_r <= pulse_nxt;
      end
   end

   assign wdt_reset_o = pulse_r;
   assign watchdog_on_o = on_r;
   assign timeout_select_o = sel_r;

   // Reset-cause flags live across chip resets; only power-up, a zero write or the level-zero mask clears them
   logic [4:0] cause_r;
   logic [4:0] cause_nxt;
   logic [4:0] cause_mask;
   logic [4:0] cause_evt;

   assign cause_mask = (level == WDCFG_LVL0) ? CAUSE_LEGACY_MASK : CAUSE_FULL_MASK;

   // Events; set beats a simultaneous zero write
   always_comb begin
      cause_evt = 5'h00;
      cause_evt[CAUSE_SCAN_BIT] = scan_reset_i;
      cause_evt[CAUSE_WD_BIT] = expire;
      cause_evt[CAUSE_BO_BIT] = brownout_reset_i;
      cause_evt[CAUSE_PIN_BIT] = pin_reset_i;
      cause_nxt = cause_r;
      if (cause_wr) begin
         cause_nxt = cause_r & wdata_i[CAUSE_W-1:0];
      end
      cause_nxt = (cause_nxt | cause_evt) & cause_mask;
   end

   // power-up sets its flag, clears the rest
   always_ff @(posedge clk_i or posedge por_i) begin
      if (por_i) begin
         cause_r <= CAUSE_POR_VAL;
      end else if (ce_i) begin
         cause_r <= cause_nxt;
      end
   end

   // Read data, registered; unmapped addresses read zero
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = rdata_r;
      if (rd_i) begin
         rdata_nxt = 8'h00;
         if (ctl_hit) begin
            rdata_nxt[CTL_UNLOCK_BIT] = unlock_r;
            rdata_nxt[CTL_ON_BIT] = on_r || (level == WDCFG_LVL2);
            rdata_nxt[CTL_SEL_MSB:0] = sel_r;
         end else if (cause_hit) begin
            rdata_nxt[CAUSE_W-1:0] = cause_r & cause_mask;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else if (ce_i) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata_o = rdata_r;

   // Checks on the control and flag logic
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_ctl_wr;
      ce_i && ctl_wr;
   endsequence

   sequence s_locked_wr;
      ce_i && ctl_wr && !unlock_r;
   endsequence

   chk_lvl2_reads_on: assert property (
      (ce_i && rd_i && ctl_hit && level == WDCFG_LVL2) |=> rdata_o[CTL_ON_BIT])
      else $error("enable read as zero at level two");

   chk_lvl2_never_off: assert property (
      (ce_i && !rst_i && level == WDCFG_LVL2) |=> on_r)
      else $error("watchdog off at level two");

   chk_window_bound: assert property (
      unlock_r |-> (win_cnt_r <= WIN_LAST))
      else $error("window counter past its end");

   chk_window_close: assert property (
      (ce_i && unlock_r && win_cnt_r == WIN_LAST && !reopen) |=> !unlock_r)
      else $error("window stayed open past four cycles");

   chk_locked_no_off: assert property (
      (s_locked_wr and (!w_on && on_r)) |=> on_r)
      else $error("enable cleared without unlock");

   chk_enable_free: assert property (
      (s_ctl_wr and w_on) |=> on_r)
      else $error("enable write ignored");

   chk_sel_locked: assert property (
      (s_locked_wr and level == WDCFG_LVL1) |=> (sel_r == $past(sel_r)))
      else $error("select changed with window closed");

   chk_sel_free: assert property (
      (s_ctl_wr and level == WDCFG_LVL0) |=> (sel_r == $past(w_sel)))
      else $error("select not taken at level zero");

   chk_open_window: assert property (
      (ce_i && reopen) |=> unlock_r ##0 (win_cnt_r == 3'h0))
      else $error("window not opened");

   chk_rst_pulse: assert property (
      (ce_i && wdt_reset_o) |=> !wdt_reset_o)
      else $error("reset pulse longer than one cycle");

   chk_wd_flag_set: assert property (
      (wdt_reset_o && level != WDCFG_LVL0) |-> cause_r[CAUSE_WD_BIT])
      else $error("watchdog flag missing on pulse");

   chk_legacy_mask: assert property (
      (level == WDCFG_LVL0) |-> (cause_r[4:2] == 3'h0))
      else $error("legacy mode shows extra flags");

   // A pulse already launched may land two cycles after disable
   chk_off_no_pulse: assert property (
      (ce_i && !on_r) [*3] |-> !wdt_reset_o)
      else $error("pulse while disabled");

endmodule : wdcfg_top
`default_nettype wire

// file: tb/wdcfg_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import wdcfg_pkg::*;
   // Short time-outs keep the run small: 4 to 512 oscillator edges
   localparam int BL = 2;
   localparam logic [7:0] CTL = CTL_IO_OFF;
   localparam logic [7:0] CAU = CAUSE_IO_OFF;
   logic clk, rst, por, ce, io_sel, wr, rd, fz_compat, fz_on, osc, restart, pin_rst, bo_rst, scan_rst;
   logic [7:0] addr, wdata, rdata;
   logic wdt_rst, wd_on;
   logic [2:0] sel;
   int num_errors = 0;
   int num_checks = 0;
   int pulses = 0;
   logic rd_d = 1'b0;
   logic pulse_d = 1'b0;
   logic [7:0] exp_q[$];

   wdcfg_top #(.BASE_LOG2(BL)) dut (.clk_i(clk), .rst_i(rst), .por_i(por), .ce_i(ce), .io_sel_i(io_sel),
      .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
      .legacy_compat_fuse_i(fz_compat), .always_on_fuse_i(fz_on), .wdt_osc_i(osc), .restart_i(restart),
      .pin_reset_i(pin_rst), .brownout_reset_i(bo_rst), .scan_reset_i(scan_rst),
      .wdt_reset_o(wdt_rst), .watchdog_on_o(wd_on), .timeout_select_o(sel));

   // Free-running system clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic report_and_stop();
      // Reads still waiting for their data count as lost
      if (exp_q.size() != 0) begin
         num_errors++;
      end
      if (num_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Write strobe for one cycle; returns once the effect has landed
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic port = 1'b1);
      @(posedge clk);
      io_sel <= port;
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
   endtask : bus_wr

   // Expected read data is queued; the monitor compares it
   task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input logic port = 1'b1);
      @(posedge clk);
      io_sel <= port;
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : bus_rd

   task automatic osc_edge();
      @(posedge clk);
      osc <= 1'b1;
      repeat (4) @(posedge clk);
      osc <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : osc_edge

   // Fuses are decoded at once; each level change also applies a chip reset
   task automatic set_level(input logic compat, input logic aon);
      @(posedge clk);
      fz_compat <= compat;
      fz_on <= aon;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask : set_level

   // Counts oscillator edges from a restart to the reset pulse
   task automatic run_to_expiry(input int n, input int pre);
      int edges;
      int p0;
      edges = 0;
      repeat (pre) osc_edge();
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      repeat (4) @(posedge clk);
      p0 = pulses;
      while (pulses == p0 && edges < 2 * n + 4) begin
         osc_edge();
         edges++;
      end
      if (pulses == p0) begin
         num_errors++;
         report_and_stop();
      end
      check(16'(edges), 16'(n));
   endtask : run_to_expiry

   // Read results and reset pulses are judged at the falling edge
   always @(posedge clk) rd_d <= rd & ce;
   always @(negedge clk) begin
      if (rd_d && exp_q.size() > 0) begin
         check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
      end
      if (wdt_rst === 1'b1) begin
         pulses++;
         check({15'h0, pulse_d}, 16'h0000);
      end
      pulse_d = wdt_rst;
   end

   // Hang guard well past the longest expected run
   initial begin
      #1000000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      int p;
      logic [7:0] m;
      void'($urandom(32'h0d6e2c25));
      {rst, por, ce, io_sel} = 4'b1111;
      {wr, rd, fz_compat, fz_on, osc, restart, pin_rst, bo_rst, scan_rst} = 9'h000;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      // reset values in both address spaces
      bus_rd(CTL, 8'h00);
      bus_rd(CAU + DATA_SPACE_BIAS, 8'h01, 1'b0);
      bus_rd(8'h22, 8'h00);
      bus_wr(CTL, 8'h08);
      check(16'(wd_on), 16'h1);
      // locked writes and unmapped writes change nothing
      repeat (4) begin
         bus_wr(CTL, {3'(($urandom())), 1'b0, 1'(($urandom())), 3'(($urandom()))});
         bus_wr({3'h0, 5'(($urandom()))}, 8'(($urandom())));
      end
      bus_rd(CTL, 8'h08);
      // window opens, then closes by itself
      bus_wr(CTL, 8'h18);
      bus_rd(CTL + DATA_SPACE_BIAS, 8'h18, 1'b0);
      repeat (6) @(posedge clk);
      bus_rd(CTL, 8'h08);
      bus_wr(CTL, 8'h00);
      check(16'(wd_on), 16'h1);
      bus_wr(CTL, 8'h18);
      bus_wr(CTL, 8'h0d);
      check({wd_on, sel}, 16'h000d);
      bus_wr(CTL, 8'h18);
      bus_wr(CTL, 8'h00);
      check(16'(wd_on), 16'h0);
      // cause flags set by events, cleared by zero writes
      // flags cleared first, then read back as zero
      bus_wr(CAU, 8'h00);
      bus_rd(CAU, 8'h00);
      for (int i = 0; i < 3; i++) begin
         // Pin, brown-out, scan in turn; scan sits above the watchdog flag
         m = 8'(1 << ((i == 2) ? CAUSE_SCAN_BIT : CAUSE_PIN_BIT + i));
         @(posedge clk);
         {scan_rst, bo_rst, pin_rst} <= 3'(1 << i);
         @(posedge clk);
         {scan_rst, bo_rst, pin_rst} <= 3'b000;
         bus_rd(CAU, m);
         bus_wr(CAU, ~m);
         bus_rd(CAU, 8'h00);
      end
      @(posedge clk);
      pin_rst <= 1'b1;
      @(posedge clk);
      pin_rst <= 1'b0;
      set_level(1'b0, 1'b0);
      bus_rd(CAU, 8'h02);
      @(posedge clk);
      por <= 1'b1;
      @(posedge clk);
      por <= 1'b0;
      bus_rd(CAU, 8'h01);
      set_level(1'b0, 1'b1);
      check(16'(wd_on), 16'h1);
      bus_wr(CTL, 8'h00);
      bus_wr(CTL, 8'h07);
      bus_rd(CTL, 8'h08);
      bus_wr(CTL, 8'h18);
      bus_wr(CTL, 8'h02);
      bus_rd(CTL, 8'h0a);
      // legacy level, with a frozen write first
      set_level(1'b1, 1'b0);
      @(posedge clk);
      ce <= 1'b0;
      bus_wr(CTL, 8'h0f);
      @(posedge clk);
      ce <= 1'b1;
      bus_rd(CTL, 8'h00);
      bus_wr(CTL, 8'h06);
      bus_rd(CTL, 8'h06);
      @(posedge clk);
      {scan_rst, bo_rst, pin_rst} <= 3'b111;
      @(posedge clk);
      {scan_rst, bo_rst, pin_rst} <= 3'b000;
      bus_rd(CAU, 8'h03);
      // every time-out code, disabled counter holds
      set_level(1'b0, 1'b0);
      p = pulses;
      repeat (8) osc_edge();
      check(16'(pulses - p), 16'h0);
      bus_wr(CAU, 8'h00);
      for (int c = 0; c < 8; c++) begin
         bus_wr(CTL, 8'h18);
         bus_wr(CTL, 8'h08 | 8'(c));
         check(16'(sel), 16'(c));
         run_to_expiry(1 << (BL + c), (c == 0) ? (1 << BL) - 1 : 0);
      end
      bus_rd(CAU, 8'h08);
      repeat (2) @(posedge clk);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
